// ---- hdl/wpaf_pkg.sv ----
package wpaf_pkg;
	localparam int NUM_FILT = 32;
	localparam int NUM_ADDR = 33;
	localparam int MASK_BITS = 128;
	localparam int DA_BYTES = 6;
	localparam int SA_END = 12;
	localparam logic [11:0] CFG_BASE = 12'h150;
	localparam logic [11:0] CFG_LAST = 12'h1CC;
	localparam logic [11:0] MASK_BASE = 12'h200;
	localparam logic [11:0] MASK_LAST = 12'h3FC;
	localparam logic [11:0] ADDR_BASE = 12'h400;
	localparam logic [11:0] ADDR_LAST = 12'h504;
	localparam logic [11:0] INT_STATUS_OFS = 12'h700;
	localparam logic [11:0] INT_CLEAR_OFS = 12'h704;
	localparam logic [11:0] INT_ENABLE_OFS = 12'h708;
	localparam logic [11:0] WAKE_STATUS_OFS = 12'h70C;
	localparam int EN_BIT = 31;
	localparam int VALID_BIT = 31;
	localparam int SRC_BIT = 30;
	localparam int WFLAG_BIT = 8;
	localparam int INT_WAKE = 0;
	localparam int INT_PERF = 1;
	localparam logic [31:0] CFG_WMASK = 32'h83FF_FFFF;
	localparam logic [31:0] AHI_WMASK = 32'hC000_FFFF;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_SEED = 16'hFFFF;
	typedef enum logic {RX_IDLE = 1'b0, RX_FRAME = 1'b1} wpaf_rx_e;
	typedef enum logic [3:0] {
		K_NONE = 4'h0, K_CFG = 4'h1, K_MASK = 4'h2, K_AHI = 4'h3, K_ALO = 4'h4,
		K_IST = 4'h5, K_ICL = 4'h6, K_IEN = 4'h7, K_WST = 4'h8
	} wpaf_kind_e;
	typedef struct packed {
		wpaf_kind_e kind;
		logic [5:0] idx;
		logic [1:0] word;
	} wpaf_sel_s;
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic good;
		logic [7:0] data;
	} wpaf_rx_s;
	typedef struct packed {
		logic [31:0] cfg;
		logic [127:0] mask;
	} wpaf_img_s;
endpackage

// ---- hdl/wpaf_top.sv ----
// Functional notes
// - Thirty-two filters, each spanning 128 frame bytes.
// - Filter enable bit 31, reset clear.
// - Address type 00 unicast, 10 multicast, X1 all.
// - Pattern offset 23:16, zero is first DA byte.
// - Mask bit j includes byte offset+j.
// - CRC equal to bits 15:0 means wake frame.
// - Mask is four words, low word first.
// - Filter zero defaults come from loaded image.
// - USB or lite reset restores filter zero image.
// - Address entry used only while valid set.
// - Bit 30 selects source versus destination address.
// - Address 47:32 in word0, 31:0 in word1.
// - Record matching filter index with wake flag.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module wpaf_top
	import wpaf_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire wpaf_pkg::wpaf_rx_s RX,
	input wire logic IMG_LOAD,
	input wire wpaf_pkg::wpaf_img_s IMG,
	input wire logic USB_RESET,
	input wire logic LITE_SOFT_RESET,
	output logic PERFECT_MATCH,
	output logic IRQ
);
	import wpaf_pkg::*;

	logic [31:0] cfg [NUM_FILT];
	logic [127:0] mask [NUM_FILT];
	logic [31:0] ahi [NUM_ADDR];
	logic [31:0] alo [NUM_ADDR];
	logic [31:0] img_cfg;
	logic [127:0] img_mask;
	logic img_ok;
	wpaf_sel_s dsel;
	logic wr, setup, restore;
	wpaf_rx_e st;
	logic [8:0] cnt, bidx;
	logic mc_q, mc_cur, beat, last;
	logic [47:0] da, sa;
	logic [15:0] crc [NUM_FILT];
	logic [15:0] ncrc [NUM_FILT];
	logic [NUM_FILT-1:0] inc, hit, en_vec;
	logic [NUM_ADDR-1:0] pf, pf_val;
	logic [4:0] first;
	logic wflag, wclr, wake_ev, pf_ev;
	logic [4:0] widx;
	logic [1:0] ist, ien, iclr;

	// Bytewise CRC, most significant bit first.
	function automatic logic [15:0] wpaf_crc16(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int b = 7; b >= 0; b--)
		begin
			r = (r[15] ^ d[b]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic wpaf_sel_s wpaf_dec(input logic [11:0] a);
		logic [11:0] r;
		wpaf_sel_s s;
		s = '{K_NONE, 6'h00, 2'h0};
		r = 12'h000;
		if (a[1:0] != 2'b00)
			s.kind = K_NONE;
		else if (a >= CFG_BASE && a <= CFG_LAST)
		begin
			r = a - CFG_BASE;
			s = '{K_CFG, r[7:2], 2'h0};
		end
		else if (a >= MASK_BASE && a <= MASK_LAST)
			s = '{K_MASK, {1'b0, a[8:4]}, a[3:2]};
		else if (a >= ADDR_BASE && a <= ADDR_LAST)
		begin
			r = a - ADDR_BASE;
			s = '{(r[2] ? K_ALO : K_AHI), r[8:3], 2'h0};
		end
		else if (a == INT_STATUS_OFS)
			s.kind = K_IST;
		else if (a == INT_CLEAR_OFS)
			s.kind = K_ICL;
		else if (a == INT_ENABLE_OFS)
			s.kind = K_IEN;
		else if (a == WAKE_STATUS_OFS)
			s.kind = K_WST;
		return s;
	endfunction

	// Zero wait states: read data is prepared during the setup cycle.
	assign PREADY = 1'b1;
	assign dsel = wpaf_dec(PADDR);
	assign setup = PSEL & ~PENABLE;
	assign wr = PSEL & PENABLE & PWRITE;
	assign restore = USB_RESET | LITE_SOFT_RESET;

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			img_ok <= 1'b0;
			img_cfg <= RST_WORD;
			img_mask <= '0;
		end
		else if (IMG_LOAD)
		begin
			img_ok <= 1'b1;
			img_cfg <= IMG.cfg & CFG_WMASK;
			img_mask <= IMG.mask;
		end
	end

	// Filter zero's image takes priority over a software write in the same cycle.
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			for (int i = 0; i < NUM_FILT; i++)
			begin
				cfg[i] <= RST_WORD;
				mask[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < NUM_FILT; i++)
			begin
				if (wr && dsel.kind == K_CFG && dsel.idx == 6'(i))
					cfg[i] <= PWDATA & CFG_WMASK;
				if (wr && dsel.kind == K_MASK && dsel.idx == 6'(i))
					mask[i][32*dsel.word +: 32] <= PWDATA;
			end
			if (restore)
			begin
				cfg[0] <= img_ok ? img_cfg : RST_WORD;
				mask[0] <= img_ok ? img_mask : '0;
			end
			else if (IMG_LOAD)
			begin
				cfg[0] <= IMG.cfg & CFG_WMASK;
				mask[0] <= IMG.mask;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			for (int e = 0; e < NUM_ADDR; e++)
			begin
				ahi[e] <= RST_WORD;
				alo[e] <= RST_WORD;
			end
		end
		else
		begin
			for (int e = 0; e < NUM_ADDR; e++)
			begin
				if (wr && dsel.kind == K_AHI && dsel.idx == 6'(e))
					ahi[e] <= PWDATA & AHI_WMASK;
				if (wr && dsel.kind == K_ALO && dsel.idx == 6'(e))
					alo[e] <= PWDATA;
			end
		end
	end

	// Beats outside a frame are dropped until the next start of frame.
	assign beat = RX.valid & (RX.sof | (st == RX_FRAME));
	assign last = beat & RX.eof;
	assign bidx = RX.sof ? 9'h000 : cnt;
	assign mc_cur = RX.sof ? RX.data[0] : mc_q;

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			st <= RX_IDLE;
			cnt <= 9'h000;
			mc_q <= 1'b0;
		end
		else if (beat)
		begin
			case (st)
				RX_IDLE: st <= RX.eof ? RX_IDLE : RX_FRAME;
				RX_FRAME: st <= RX.eof ? RX_IDLE : RX_FRAME;
				default: st <= RX_IDLE;
			endcase
			cnt <= (bidx == 9'h1FF) ? bidx : bidx + 9'h001;
			mc_q <= mc_cur;
		end
	end

	// First byte received lands in the low bits, as in the entry's second word.
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			da <= '0;
			sa <= '0;
		end
		else if (beat && bidx < 9'(DA_BYTES))
			da[8*bidx[2:0] +: 8] <= RX.data;
		else if (beat && bidx < 9'(SA_END))
			sa[8*(bidx[3:0] - 4'(DA_BYTES)) +: 8] <= RX.data;
	end

	for (genvar g = 0; g < NUM_FILT; g++)
	begin : g_filt
		logic [8:0] off, rel;
		logic [15:0] base;
		logic type_ok;
		assign off = {1'b0, cfg[g][23:16]};
		assign rel = bidx - off;
		assign en_vec[g] = cfg[g][EN_BIT];
		assign inc[g] = beat & en_vec[g] & (bidx >= off) & (rel < 9'(MASK_BITS)) & mask[g][rel[6:0]];
		assign base = RX.sof ? CRC_SEED : crc[g];
		assign ncrc[g] = inc[g] ? wpaf_crc16(base, RX.data) : base;
		assign type_ok = cfg[g][24] | (cfg[g][25] ? mc_cur : ~mc_cur);
		assign hit[g] = last & RX.good & en_vec[g] & type_ok & (ncrc[g] == cfg[g][15:0]);
		always_ff @(posedge CLK_SYS or negedge RESETN)
		begin
			if (!RESETN)
				crc[g] <= CRC_SEED;
			else if (beat)
				crc[g] <= ncrc[g];
		end
	end

	// Entries compare against addresses held from earlier bytes, so a frame shorter than seven bytes (thirteen for a source entry)
	// gives no meaningful perfect match at its last byte.
	for (genvar e = 0; e < NUM_ADDR; e++)
	begin : g_addr
		assign pf_val[e] = ahi[e][VALID_BIT];
		assign pf[e] = pf_val[e] & ((ahi[e][SRC_BIT] ? sa : da) == {ahi[e][15:0], alo[e]});
	end

	always_comb
	begin
		first = 5'h00;
		for (int i = NUM_FILT - 1; i >= 0; i--)
		begin
			if (hit[i])
				first = 5'(i);
		end
	end

	assign wake_ev = |hit;
	assign pf_ev = last & RX.good & (|pf);
	assign wclr = wr & (dsel.kind == K_WST) & PWDATA[WFLAG_BIT];
	assign iclr = (wr && dsel.kind == K_ICL) ? PWDATA[1:0] : 2'b00;

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
			PERFECT_MATCH <= 1'b0;
		else if (last)
			PERFECT_MATCH <= pf_ev;
	end

	// A new wake frame wins over a clear arriving in the same cycle.
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			wflag <= 1'b0;
			widx <= 5'h00;
		end
		else if (wake_ev)
		begin
			wflag <= 1'b1;
			if (!wflag || wclr)
				widx <= first;
		end
		else if (wclr)
			wflag <= 1'b0;
	end

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ist <= 2'h0;
			ien <= 2'h0;
			IRQ <= 1'b0;
		end
		else
		begin
			// A set beats a clear in the same cycle, so no event is lost.
			ist <= (ist & ~iclr) | {pf_ev, wake_ev};
			if (wr && dsel.kind == K_IEN)
				ien <= PWDATA[1:0];
			IRQ <= |(ist & ien);
		end
	end

	// A read shows the registers as they stood at the setup edge; a restore during the access cycle
	// is seen only by the next read.
	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			PRDATA <= RST_WORD;
			PSLVERR <= 1'b0;
		end
		else if (setup)
		begin
			PSLVERR <= (dsel.kind == K_NONE);
			case (dsel.kind)
				K_CFG: PRDATA <= cfg[dsel.idx[4:0]];
				K_MASK: PRDATA <= mask[dsel.idx[4:0]][32*dsel.word +: 32];
				K_AHI: PRDATA <= ahi[dsel.idx];
				K_ALO: PRDATA <= alo[dsel.idx];
				K_IST: PRDATA <= {30'h0000_0000, ist};
				K_IEN: PRDATA <= {30'h0000_0000, ien};
				K_WST: PRDATA <= {23'h00_0000, wflag, 3'h0, widx};
				default: PRDATA <= RST_WORD;
			endcase
		end
	end

	// Checks run on the system clock and stay quiet while reset is held.
	default clocking wpaf_cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESETN);

	en_gate_a: assert property ((hit & ~en_vec) == '0)
		else $error("Disabled filter reported a match.");
	type_uc_a: assert property (hit[0] && cfg[0][25:24] == 2'b00 |-> !mc_cur)
		else $error("Unicast-only filter matched a multicast frame.");
	skip_a: assert property (beat && !RX.sof && !inc[0] |=> crc[0] == $past(crc[0]))
		else $error("Masked-out byte changed the CRC.");
	wake_set_a: assert property (hit != '0 |=> wflag && ist[INT_WAKE])
		else $error("Wake match did not set the flag.");
	idx_a: assert property (hit != '0 && !wflag |=> widx == $past(first))
		else $error("Matching filter index not recorded.");
	restore_a: assert property (restore |=> cfg[0] == ($past(img_ok) ? $past(img_cfg) : RST_WORD))
		else $error("Filter zero not restored from image.");
	mask_rd_a: assert property (setup && !PWRITE && dsel.kind == K_MASK && dsel.idx == 6'h00
		&& dsel.word == 2'h3 |=> PRDATA == $past(mask[0][127:96]))
		else $error("Mask high word read wrong.");
	pf_valid_a: assert property (last && RX.good && pf_val == '0 |=> !PERFECT_MATCH)
		else $error("Perfect match without a valid entry.");
	ahi_wr_a: assert property (wr && PADDR == ADDR_BASE |=> ahi[0][15:0] == $past(PWDATA[15:0]))
		else $error("Entry high address bits not stored.");
	irq_a: assert property ((ist & ien) != 2'h0 |=> IRQ)
		else $error("Interrupt not raised.");
	slverr_a: assert property (setup && dsel.kind == K_NONE |=> PSLVERR)
		else $error("Unmapped address not flagged.");
	off_gate_a: assert property (beat && bidx < {1'b0, cfg[0][23:16]} |-> !inc[0])
		else $error("Byte before the pattern offset entered the CRC.");
	bad_frame_a: assert property (last && !RX.good |-> !wake_ev && !pf_ev)
		else $error("Errored frame raised a match event.");
	flag_clr_a: assert property (wclr && !wake_ev |=> !wflag)
		else $error("Wake flag not cleared.");
	img_load_a: assert property (IMG_LOAD && !restore |=> cfg[0] == ($past(IMG.cfg) & CFG_WMASK))
		else $error("Filter zero not loaded from image.");

	wake_c: cover property (hit != '0 ##1 IRQ);
	perf_c: cover property (pf_ev && ahi[0][SRC_BIT]);
	restore_c: cover property (restore && img_ok);
	bad_c: cover property (last && !RX.good);
endmodule

// ---- test/wpaf_phy_model.sv ----
`timescale 1ns/1ns
// Receive side of the PHY. Between beats the data lines show the inverse of the last byte,
// so a design that samples outside a beat sees a changing value rather than a stale one.
module wpaf_phy_model
	import wpaf_pkg::*;
(
	input wire logic clk,
	output wpaf_pkg::wpaf_rx_s rx
);
	initial rx = '0;
	task automatic send(input int n, input logic good);
		for (int k = 0; k < n; k++)
		begin
			@(posedge clk);
			rx <= '{valid: 1'b1, sof: k == 0, eof: k == n - 1, good: good, data: 8'h10 + k[7:0]};
		end
		@(posedge clk);
		rx <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, good: 1'b0, data: ~rx.data};
	endtask
endmodule

// ---- test/tb_wpaf_top.sv ----
`timescale 1ns/1ns
module tb_wpaf_top
	import wpaf_pkg::*;
;
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, lerr;
	logic img_load, usb_reset, lite_reset, perfect_match, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] crc;
	wpaf_img_s img;
	wpaf_rx_s rx;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [31:0] wcfg [3] = '{32'h0002_0000, 32'h8202_0000, 32'h8102_0000};
	logic [31:0] ahi [3] = '{32'h8000_1514, 32'hC000_1514, 32'h0000_1514};

	wpaf_top i_wpaf_top(.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RX(rx), .IMG_LOAD(img_load), .IMG(img), .USB_RESET(usb_reset),
		.LITE_SOFT_RESET(lite_reset), .PERFECT_MATCH(perfect_match), .IRQ(irq));
	wpaf_phy_model i_wpaf_phy_model(.clk(clk_sys), .rx(rx));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		lerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic fb;
		for (int i = 7; i >= 0; i--)
		begin
			fb = c[15] ^ b[i];
			c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return c;
	endfunction

	task final_report;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		resetn = 1'b0;
		{psel, penable, pwrite, img_load, usb_reset, lite_reset} = '0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		img = '0;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(CFG_BASE, 32'h0000_0000);
		rd(ADDR_BASE, 32'h0000_0000);
		wr(CFG_BASE + 12'h004, 32'hFFFF_FFFF);
		rd(CFG_BASE + 12'h004, CFG_WMASK);
		// Filter one is now disabled, with an empty mask and an expected CRC of zero, so it matches no frame.
		wr(CFG_BASE + 12'h004, 32'h0000_0000);
		wr(ADDR_BASE + 12'h008, 32'hFFFF_FFFF);
		rd(ADDR_BASE + 12'h008, AHI_WMASK);
		rd(12'h0F0, 32'h0000_0000);
		chk({31'h0, lerr}, 32'h1);
		for (int w = 0; w < 4; w++)
			wr(MASK_BASE + 12'h030 + 12'(4 * w), 32'(w + 1));
		for (int w = 0; w < 4; w++)
			rd(MASK_BASE + 12'h030 + 12'(4 * w), 32'(w + 1));
		wr(INT_ENABLE_OFS, 32'h0000_0003);
		// Mask word 0 selects only byte offset+0, so the expected CRC covers frame byte 2 alone.
		crc = crc_byte(CRC_SEED, 8'h12);
		for (int t = 0; t < 3; t++)
		begin
			wr(CFG_BASE + 12'h00C, wcfg[t] | {16'h0000, crc});
			i_wpaf_phy_model.send(14, 1'b1);
			rd(INT_STATUS_OFS, {31'h0, t == 2});
		end
		rd(WAKE_STATUS_OFS, 32'h0000_0103);
		chk({31'h0, irq}, 32'h1);
		wr(INT_CLEAR_OFS, 32'h0000_0003);
		wr(WAKE_STATUS_OFS, 32'h0000_0100);
		rd(INT_STATUS_OFS, 32'h0000_0000);
		// Only the flag clears; the index keeps its last value and means nothing while the flag is low.
		rd(WAKE_STATUS_OFS, 32'h0000_0003);
		chk({31'h0, irq}, 32'h0);
		i_wpaf_phy_model.send(14, 1'b0);
		rd(INT_STATUS_OFS, 32'h0000_0000);
		for (int t = 0; t < 3; t++)
		begin
			wr(ADDR_BASE, 32'h0000_0000);
			wr(ADDR_BASE + 12'h004, 32'h1312_1110);
			wr(ADDR_BASE, ahi[t]);
			i_wpaf_phy_model.send(14, 1'b1);
			repeat (2) @(posedge clk_sys);
			chk({31'h0, perfect_match}, {31'h0, t == 0});
		end
		wr(CFG_BASE, 32'h8000_00AA);
		@(posedge clk_sys) usb_reset <= 1'b1;
		@(posedge clk_sys) usb_reset <= 1'b0;
		rd(CFG_BASE, 32'h0000_0000);
		@(posedge clk_sys)
		begin
			img <= '{cfg: 32'h8101_5A5A, mask: {96'h0, 32'h0F0F_0000}};
			img_load <= 1'b1;
		end
		@(posedge clk_sys) img_load <= 1'b0;
		rd(CFG_BASE, 32'h8101_5A5A);
		wr(CFG_BASE, 32'h0000_0000);
		wr(MASK_BASE, 32'h0000_0000);
		@(posedge clk_sys) lite_reset <= 1'b1;
		@(posedge clk_sys) lite_reset <= 1'b0;
		rd(CFG_BASE, 32'h8101_5A5A);
		rd(MASK_BASE, 32'h0F0F_0000);
		final_report();
	end
endmodule
